/* File: branch_and_coproc_dispatch.v */
// branch execution and coprocessor dispatch stage
// ------------------------------
// ------------------------------
`timescale 1ns/1ps
module branch_and_coproc_dispatch
#(
   parameter CP_N = 16
)
(
   // clock, reset, enable
   input wire core_clk_i,
   input wire rst_i,
   input wire clk_en_i,
   // instruction in execute
   input wire instr_valid_i,
   input wire [31:0] instr_i,
   input wire [31:0] instr_addr_i,
   input wire [31:0] program_counter_reg_i,
   // processor state
   input wire mode32_i,
   input wire [3:0] flags_i,
   input wire [31:0] current_status_word_i,
   input wire [31:0] saved_status_word_i,
   input wire privileged_i,
   // flag-setting pc load request
   input wire pc_load_s_i,
   // coprocessor answers, one per number
   input wire [CP_N-1:0] cp_present_i,
   input wire self_ctrl_ok_i,
   // branch results
   output reg branch_taken_o,
   output reg flush_o,
   output reg [31:0] fetch_addr_o,
   output reg link_we_o,
   output reg [31:0] link_register_o,
   // coprocessor dispatch
   output reg cp_issue_o,
   output reg [3:0] cp_num_o,
   output reg [31:0] cp_instr_o,
   output reg self_ctrl_o,
   output reg undef_trap_o,
   // status restore
   output reg status_restore_o,
   output reg [31:0] status_word_o
);
`include "branch_dispatch_defs.vh"
   // ------------------------------
   // decode
   // ------------------------------
   wire cond_pass;
   reg is_branch;
   reg is_coproc;
   wire link_req;
   wire [3:0] cp_sel;
   wire [31:0] pc_used;
   wire [31:0] offs_ext;
   wire [31:0] sum32;
   wire [31:0] target;
   wire [31:0] ret_addr;
   wire cp_answer;
   wire [CP_N-1:0] cp_resp;

   cond_check u_cond
   (
      .cond_i (instr_i[`COND_MSB:`COND_LSB]),
      .flags_i (flags_i),
      .pass_o (cond_pass)
   );

   // ------------------------------
   // class decode
   // ------------------------------
   // 101 is a branch; 110 and 111 are coprocessor space, except that
   // 111 with bit 24 set is the software interrupt and is left alone
   always @*
   begin
      is_branch = 1'b0;
      is_coproc = 1'b0;
      case (instr_i[27:25])
         `CLASS_BRANCH:
         begin
            is_branch = 1'b1;
         end
         {`CLASS_COPROC_HI, 1'b0}:
         begin
            is_coproc = 1'b1;
         end
         {`CLASS_COPROC_HI, 1'b1}:
         begin
            is_coproc = ~instr_i[24];
         end
         default:
         begin
            is_branch = 1'b0;
            is_coproc = 1'b0;
         end
      endcase
   end

   // link bit and coprocessor number fields
   assign link_req = instr_i[`LINK_BIT];
   assign cp_sel = instr_i[`CPNUM_MSB:`CPNUM_LSB];

   // the visible pc input is not used: the instruction address already
   // fixes the prefetch distance, so a stalled pc cannot skew targets
   // prefetch puts pc two words ahead of the branch
   assign pc_used = instr_addr_i + `PREFETCH_BYTES;
   // signed word offset, shifted and sign-extended
   assign offs_ext = {{6{instr_i[`OFFS_MSB]}}, instr_i[`OFFS_MSB:`OFFS_LSB], 2'b00};
   // 32-bit add, carry out simply dropped
   assign sum32 = pc_used + offs_ext;
   // 26-bit mode keeps only the word address field
   assign target = mode32_i ? sum32 : (sum32 & `PC26_MASK);
   assign ret_addr = instr_addr_i + `WORD_BYTES;

   // per-number answer lines; own number answered internally
   genvar g;
   generate
      for (g = 0; g < CP_N; g = g + 1)
      begin : g_resp
         if (g == 15)
         begin : g_self
            assign cp_resp[g] = self_ctrl_ok_i;
         end
         else
         begin : g_ext
            assign cp_resp[g] = cp_present_i[g];
         end
      end
   endgenerate
   // answer of the selected coprocessor number
   assign cp_answer = cp_resp[cp_sel];

   // ------------------------------
   // execute stage registers
   // ------------------------------
   always @(posedge core_clk_i)
   begin
      // reset clears every output and pulse
      if (rst_i)
      begin
         branch_taken_o <= 1'b0;
         flush_o <= 1'b0;
         fetch_addr_o <= 32'h00000000;
         link_we_o <= 1'b0;
         link_register_o <= 32'h00000000;
         cp_issue_o <= 1'b0;
         cp_num_o <= 4'h0;
         cp_instr_o <= 32'h00000000;
         self_ctrl_o <= 1'b0;
         undef_trap_o <= 1'b0;
         status_restore_o <= 1'b0;
         status_word_o <= 32'h00000000;
      end
      else if (clk_en_i)
      begin
         // pulses default low, so each lasts one enabled cycle
         branch_taken_o <= 1'b0;
         flush_o <= 1'b0;
         link_we_o <= 1'b0;
         cp_issue_o <= 1'b0;
         self_ctrl_o <= 1'b0;
         undef_trap_o <= 1'b0;
         status_restore_o <= 1'b0;
         // only a valid instruction with a passing condition acts
         if (instr_valid_i & cond_pass)
         begin
            // branch: redirect fetch and drop the prefetched words
            if (is_branch)
            begin
               branch_taken_o <= 1'b1;
               flush_o <= 1'b1;
               fetch_addr_o <= target;
               // link value written only when the link bit is set
               if (link_req)
               begin
                  link_we_o <= 1'b1;
                  if (mode32_i)
                     link_register_o <= ret_addr;
                  else
                     link_register_o <= (ret_addr & `PC26_MASK) |
                        (current_status_word_i & `PSR26_MASK);
               end
            end
            else if (is_coproc)
            begin
               // coprocessor: send out, run locally, or trap
               cp_num_o <= cp_sel;
               cp_instr_o <= instr_i;
               if (cp_answer)
               begin
                  cp_issue_o <= (cp_sel != `CP_SELF);
                  self_ctrl_o <= (cp_sel == `CP_SELF);
               end
               else
                  undef_trap_o <= 1'b1;
            end
         end
         // flag-setting pc load in privileged mode restores state
         if (pc_load_s_i & privileged_i)
         begin
            status_restore_o <= 1'b1;
            status_word_o <= saved_status_word_i;
         end
      end
   end
endmodule // branch_and_coproc_dispatch

/* File: branch_and_coproc_dispatch_test.sv */
// self-checking bench for the dispatch block
`timescale 1ns/1ps
`include "branch_dispatch_defs.vh"
module branch_and_coproc_dispatch_test;
   reg core_clk_i = 0, rst_i = 1, clk_en_i = 1, instr_valid_i = 0, mode32_i = 0;
   reg privileged_i = 0, pc_load_s_i = 0;
   reg [31:0] instr_i = 0, instr_addr_i = 0, program_counter_reg_i = 0;
   reg [31:0] current_status_word_i = 0, saved_status_word_i = 0, w, t, lk;
   reg [3:0] flags_i = 0, c, n;
   reg [1:0] unit_on = 0;
   wire [15:0] cp_present_i;
   wire self_ctrl_ok_i, branch_taken_o, flush_o, link_we_o, cp_issue_o, self_ctrl_o;
   wire undef_trap_o, status_restore_o;
   wire [31:0] fetch_addr_o, link_register_o, cp_instr_o, status_word_o;
   wire [3:0] cp_num_o;
   integer seed = 59479, n_fail = 0, comparisons = 0, cyc = 0, i;
   reg [138:0] q[$];
   reg [138:0] e;
   reg ok, av;
   initial forever #2 core_clk_i = ~core_clk_i;
   branch_and_coproc_dispatch u_branch_and_coproc_dispatch (.*);
   coproc_bank_model u_coproc_bank_model (.core_clk_i, .unit_on_i(unit_on),
      .present_o(cp_present_i), .self_ok_o(self_ctrl_ok_i));
   task tally_and_finish;
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input [138:0] g, input [138:0] e);
      comparisons = comparisons + 1;
      if (g !== e)
      begin
         n_fail = n_fail + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // hang guard
   always @(posedge core_clk_i)
   begin
      cyc = cyc + 1;
      if (cyc > 2000)
      begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end
   // result watcher takes the oldest note; a frozen cycle shows nothing new
   always @(posedge core_clk_i)
   begin
      #1;
      if (clk_en_i & (branch_taken_o | link_we_o | cp_issue_o | self_ctrl_o | undef_trap_o
         | status_restore_o))
         chk({status_restore_o, status_restore_o ? status_word_o : 32'h0,
            (cp_issue_o | self_ctrl_o | undef_trap_o) ? cp_instr_o : 32'h0,
            branch_taken_o, flush_o, link_we_o, cp_issue_o, self_ctrl_o, undef_trap_o,
            branch_taken_o ? fetch_addr_o : 32'h0, link_we_o ? link_register_o : 32'h0,
            (cp_issue_o | self_ctrl_o | undef_trap_o) ? cp_num_o : 4'h0},
            q.size() ? q.pop_front() : 139'h0);
   end
   // condition table worked from the flag meanings
   function cond_ok(input [3:0] cc, input [3:0] f);
      case (cc)
         `CC_EQ: cond_ok = f[2];
         `CC_NE: cond_ok = !f[2];
         `CC_CS: cond_ok = f[1];
         `CC_CC: cond_ok = !f[1];
         `CC_MI: cond_ok = f[3];
         `CC_PL: cond_ok = !f[3];
         `CC_VS: cond_ok = f[0];
         `CC_VC: cond_ok = !f[0];
         `CC_HI: cond_ok = f[1] && !f[2];
         `CC_LS: cond_ok = !f[1] || f[2];
         `CC_GE: cond_ok = f[3] == f[0];
         `CC_LT: cond_ok = f[3] != f[0];
         `CC_GT: cond_ok = !f[2] && f[3] == f[0];
         `CC_LE: cond_ok = f[2] || f[3] != f[0];
         `CC_AL: cond_ok = 1'b1;
         default: cond_ok = 1'b0;
      endcase
   endfunction
   // random branch and coprocessor stream
   initial
   begin
      repeat (4) @(negedge core_clk_i);
      rst_i = 0;
      for (i = 0; i < 400; i = i + 1)
      begin
         w = $random(seed);
         c = w[31:28];
         if (w[5]) w[27:25] = `CLASS_BRANCH;
         else if (w[6]) w[27:25] = {`CLASS_COPROC_HI, ~w[24]};
         else w[27:25] = {1'b0, w[26:25]};
         instr_i = w;
         instr_valid_i = (i % 8) != 7;
         clk_en_i = ($random(seed) & 7) != 0;
         flags_i = $random(seed);
         mode32_i = $random(seed);
         unit_on = $random(seed);
         {privileged_i, pc_load_s_i} = $random(seed);
         instr_addr_i = $random(seed) & 32'hfffffffc;
         program_counter_reg_i = instr_addr_i + `PREFETCH_BYTES;
         current_status_word_i = $random(seed);
         saved_status_word_i = $random(seed);
         // let the partner's answers settle before reading them
         #1;
         ok = instr_valid_i & clk_en_i & cond_ok(c, flags_i);
         n = w[11:8];
         av = (n == `CP_SELF) ? self_ctrl_ok_i : cp_present_i[n];
         t = instr_addr_i + 32'h8 + {{6{w[23]}}, w[23:0], 2'h0};
         lk = instr_addr_i + 32'h4;
         if (!mode32_i)
         begin
            t = t & `PC26_MASK;
            lk = (lk & `PC26_MASK) | (current_status_word_i & `PSR26_MASK);
         end
         e = 0;
         if (ok && w[5]) e[73:0] = {2'h3, w[24], 3'h0, t, w[24] ? lk : 32'h0, 4'h0};
         if (ok && !w[5] && w[6])
            e[105:0] = {w, 3'h0, av & n != `CP_SELF, av & n == `CP_SELF, !av, 64'h0, n};
         if (clk_en_i & privileged_i & pc_load_s_i) e[138:106] = {1'b1, saved_status_word_i};
         if (e != 0) q.push_back(e);
         @(negedge core_clk_i);
      end
      instr_valid_i = 0;
      pc_load_s_i = 0;
      clk_en_i = 1;
      repeat (3) @(negedge core_clk_i);
      chk(q.size(), 139'h0);
      tally_and_finish;
   end
endmodule // branch_and_coproc_dispatch_test

/* File: branch_dispatch_chk.sv */
// assertion checker for the dispatch block
`timescale 1ns/1ps
module branch_dispatch_chk
#(
   parameter CP_N = 16
)
(
   // watched ports
   input wire core_clk_i, rst_i, clk_en_i, instr_valid_i, mode32_i,
   input wire privileged_i, pc_load_s_i, self_ctrl_ok_i,
   input wire [31:0] instr_i, instr_addr_i, fetch_addr_o, link_register_o,
   input wire [CP_N-1:0] cp_present_i,
   input wire branch_taken_o, flush_o, link_we_o, cp_issue_o,
   input wire self_ctrl_o, undef_trap_o, status_restore_o
);
   // accepted always-condition instruction classes
   wire ok = clk_en_i & instr_valid_i;
   wire al = ok & (instr_i[31:28] == 4'he);
   wire br = al & (instr_i[27:25] == 3'h5);
   wire cp = al & (instr_i[27:26] == 2'h3) & ~(&instr_i[25:24]);
   wire [3:0] n = instr_i[11:8];
   wire [31:0] tgt = instr_addr_i + 32'h8 + {{6{instr_i[23]}}, instr_i[23:0], 2'h0};
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   br_fires_a: assert property (br |=> branch_taken_o && flush_o)
      else $error("taken branch gave no flush");
   tgt32_a: assert property (br && mode32_i |=> fetch_addr_o == $past(tgt))
      else $error("wide target wrong");
   tgt26_a: assert property (br && !mode32_i
      |=> fetch_addr_o == ($past(tgt) & 32'h03fffffc))
      else $error("narrow target wrong");
   link32_a: assert property (br && instr_i[24] && mode32_i
      |=> link_we_o && link_register_o == $past(instr_addr_i) + 32'h4)
      else $error("wide link value wrong");
   no_link_a: assert property (br && !instr_i[24] |=> !link_we_o)
      else $error("plain branch wrote link");
   never_runs_a: assert property (ok && instr_i[31:28] == 4'hf
      |=> !(branch_taken_o | cp_issue_o | undef_trap_o | self_ctrl_o))
      else $error("never condition executed");
   absent_trap_a: assert property (cp && n != 4'hf && !cp_present_i[n]
      |=> undef_trap_o && !cp_issue_o)
      else $error("absent unit did not trap");
   self_unit_a: assert property (cp && n == 4'hf && self_ctrl_ok_i
      |=> self_ctrl_o && !cp_issue_o)
      else $error("own number went outside");
   restore_a: assert property (clk_en_i && pc_load_s_i && privileged_i
      |=> status_restore_o)
      else $error("status not restored");
endmodule // branch_dispatch_chk
bind branch_and_coproc_dispatch branch_dispatch_chk #(.CP_N(CP_N)) u_chk (.core_clk_i, .rst_i,
   .clk_en_i, .instr_valid_i, .mode32_i, .privileged_i, .pc_load_s_i, .self_ctrl_ok_i, .instr_i,
   .instr_addr_i, .fetch_addr_o, .link_register_o, .cp_present_i, .branch_taken_o, .flush_o,
   .link_we_o, .cp_issue_o, .self_ctrl_o, .undef_trap_o, .status_restore_o);

/* File: branch_dispatch_defs.vh */
// constants for the branch and coprocessor dispatch block
`ifndef BRANCH_DISPATCH_DEFS_VH
`define BRANCH_DISPATCH_DEFS_VH
// instruction fields
`define COND_MSB 31
`define COND_LSB 28
`define LINK_BIT 24
`define OFFS_MSB 23
`define OFFS_LSB 0
`define OFFS_W 24
`define CPNUM_MSB 11
`define CPNUM_LSB 8
// class decode: bits 27:25
`define CLASS_BRANCH 3'h5
`define CLASS_COPROC_HI 2'h3
// coprocessor numbers
`define CP_COUNT 16
`define CP_SELF 4'hf
// prefetch distance in bytes, two words
`define PREFETCH_BYTES 32'h00000008
`define WORD_BYTES 32'h00000004
// 26-bit configuration pc field mask, bits 25:2
`define PC26_MASK 32'h03fffffc
`define PSR26_MASK 32'hfc000003
// condition codes
`define CC_EQ 4'h0
`define CC_NE 4'h1
`define CC_CS 4'h2
`define CC_CC 4'h3
`define CC_MI 4'h4
`define CC_PL 4'h5
`define CC_VS 4'h6
`define CC_VC 4'h7
`define CC_HI 4'h8
`define CC_LS 4'h9
`define CC_GE 4'ha
`define CC_LT 4'hb
`define CC_GT 4'hc
`define CC_LE 4'hd
`define CC_AL 4'he
`endif

/* File: cond_check.v */
// condition field evaluation against the core flags
`timescale 1ns/1ps
module cond_check
(
   // condition and flags
   input wire [3:0] cond_i,
   input wire [3:0] flags_i,
   // result
   output reg pass_o
);
`include "branch_dispatch_defs.vh"
   wire n_f;
   wire z_f;
   wire c_f;
   wire v_f;
   assign n_f = flags_i[3];
   assign z_f = flags_i[2];
   assign c_f = flags_i[1];
   assign v_f = flags_i[0];
   // decode the condition from the core flags only
   always @*
   begin
      case (cond_i)
         `CC_EQ: pass_o = z_f;
         `CC_NE: pass_o = ~z_f;
         `CC_CS: pass_o = c_f;
         `CC_CC: pass_o = ~c_f;
         `CC_MI: pass_o = n_f;
         `CC_PL: pass_o = ~n_f;
         `CC_VS: pass_o = v_f;
         `CC_VC: pass_o = ~v_f;
         `CC_HI: pass_o = c_f & ~z_f;
         `CC_LS: pass_o = ~c_f | z_f;
         `CC_GE: pass_o = (n_f == v_f);
         `CC_LT: pass_o = (n_f != v_f);
         `CC_GT: pass_o = ~z_f & (n_f == v_f);
         `CC_LE: pass_o = z_f | (n_f != v_f);
         `CC_AL: pass_o = 1'b1;
         default: pass_o = 1'b0; // never condition
      endcase
   end
endmodule // cond_check

/* File: coproc_bank_model.sv */
// coprocessor presence model for the dispatch block
`timescale 1ns/1ps
module coproc_bank_model
(
   // control and answers
   input wire core_clk_i,
   input wire [1:0] unit_on_i,
   output wire [15:0] present_o,
   output wire self_ok_o
);
   reg odd_q = 1'b0;
   // bit 15 is ignored by the core, so it toggles
   always @(posedge core_clk_i) odd_q <= ~odd_q;
   // float unit on numbers 1 and 2, absent ones trap
   assign present_o = {odd_q, 12'h0a5, unit_on_i[0], unit_on_i[0], 1'b1};
   assign self_ok_o = unit_on_i[1];
endmodule // coproc_bank_model
